/* File: rtl/usb_pin_ctrl_defs.svh */
`ifndef USB_PIN_CTRL_DEFS_SVH
`define USB_PIN_CTRL_DEFS_SVH

// Clock
`define CLK_PERIOD_NS 10

// Register byte offsets
`define OFS_USB_CTRL 5'h00
`define OFS_CPU_CTRL 5'h04
`define OFS_PIN_CTRL 5'h08
`define OFS_POWER 5'h0c
`define OFS_IRQ_FLAGS 5'h10
`define OFS_STATUS 5'h14

// Field positions
`define USB_CONNECT_BIT 0
`define USB_GATE_BIT 1
`define CPU_IE_BIT 0
`define PIN_LEVEL_BIT 0
`define PIN_POL_BIT 1
`define POWER_SUSPEND_BIT 0
`define FLAGS_MSB 5
`define STAT_PRESENT_BIT 0
`define STAT_OSC_BIT 1
`define STAT_PULLUP_BIT 2
`define STAT_CHIP_RST_BIT 3

// Reset values
`define USB_CTRL_RST 2'h0
`define PIN_CTRL_RST 2'h1
`define FLAGS_RST 6'h00

// Timing
`define SUSPEND_ENTER_MAX_US 5
`define SUSPEND_EXIT_TYP_MS 3
`define IRQ_EDGE_GAP_NS 100
`define OSC_TIMER_W 19
`define GAP_W 4

`endif

/* File: rtl/usb_pin_ctrl_pkg.sv */
package usb_pin_ctrl_pkg;

   typedef enum logic [3:0] {
      OSC_RUN = 4'h1,
      OSC_ENTERING = 4'h2,
      OSC_STOPPED = 4'h4,
      OSC_STARTING = 4'h8
   } osc_state_t;

   typedef struct packed {
      logic osc_ready;
      logic bus_resume;
      logic bus_suspend;
      logic packet_sent;
      logic packet_received;
      logic bus_power_lost;
   } irq_flags_t;

   typedef struct packed {
      logic bus_power_gating_enable;
      logic connect;
   } usb_ctrl_t;

   typedef struct packed {
      logic irq_edge_polarity_select;
      logic irq_level_mode_select;
   } pin_ctrl_t;

endpackage

/* File: rtl/usb_pin_ctrl.sv */
`timescale 1ns/10ps
`include "usb_pin_ctrl_defs.svh"

module usb_pin_ctrl #(
   parameter int unsigned OSC_START_CYCLES = (`SUSPEND_EXIT_TYP_MS * 1000000) / `CLK_PERIOD_NS
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic chip_reset_pin_n,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic bus_power_sense_input,
   input wire logic packet_received_evt,
   input wire logic packet_sent_evt,
   input wire logic bus_suspend_evt,
   input wire logic bus_resume_evt,
   output logic pullup_connect,
   output logic irq_pin_out,
   output logic irq_pin_oe,
   output logic oscillator_enable
);

   localparam int unsigned ENTER_CYC = (`SUSPEND_ENTER_MAX_US * 1000) / `CLK_PERIOD_NS;
   localparam int unsigned GAP_CYC =
      (`IRQ_EDGE_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

   logic [1:0] rst_pipe;
   logic rst_n;
   logic chip_rst_meta;
   logic chip_rst_sync;
   logic chip_reset;
   logic vbus_meta;
   logic bus_power_present;
   logic vbus_prev;
   logic ack;
   logic wr_en;
   logic [31:0] next_readdata;
   usb_pin_ctrl_pkg::usb_ctrl_t usb_control_reg;
   usb_pin_ctrl_pkg::pin_ctrl_t pin_control_reg;
   logic irq_pin_enable;
   logic suspend_request;
   usb_pin_ctrl_pkg::irq_flags_t flags;
   usb_pin_ctrl_pkg::irq_flags_t prev_flags;
   usb_pin_ctrl_pkg::irq_flags_t set_vec;
   logic [`FLAGS_MSB:0] clr_vec;
   logic pending;
   logic edge_event;
   logic [`GAP_W-1:0] gap_cnt;
   logic asserted;
   usb_pin_ctrl_pkg::osc_state_t osc_state;
   usb_pin_ctrl_pkg::osc_state_t next_osc_state;
   logic [`OSC_TIMER_W-1:0] osc_timer;
   logic osc_ready_pulse;

   // Single rising edge everywhere; reset released through two stages
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // Pin inputs; a 200 ns pulse spans many cycles so the synchroniser catches it
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         chip_rst_meta <= 1'b0;
         chip_rst_sync <= 1'b0;
      end else begin
         chip_rst_meta <= chip_reset_pin_n;
         chip_rst_sync <= chip_rst_meta;
      end
   end
   // No endpoint storage here, so no endpoint data claims to survive chip reset
   assign chip_reset = ~chip_rst_sync;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         vbus_meta <= 1'b0;
         bus_power_present <= 1'b0;
         vbus_prev <= 1'b0;
      end else begin
         vbus_meta <= bus_power_sense_input;
         bus_power_present <= vbus_meta;
         vbus_prev <= bus_power_present;
      end
   end

   // Bus slave: one wait state on every access
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= (read | write) & ~ack;
      end
   end
   assign waitrequest = (read | write) & ~ack;
   assign wr_en = write & ack & byteenable[0];

   always_comb begin
      next_readdata = 32'h0;
      case (address)
         `OFS_USB_CTRL: next_readdata[1:0] = usb_control_reg;
         `OFS_CPU_CTRL: next_readdata[`CPU_IE_BIT] = irq_pin_enable;
         `OFS_PIN_CTRL: next_readdata[1:0] = pin_control_reg;
         `OFS_POWER: next_readdata[`POWER_SUSPEND_BIT] = suspend_request;
         `OFS_IRQ_FLAGS: next_readdata[`FLAGS_MSB:0] = flags;
         `OFS_STATUS: begin
            next_readdata[`STAT_PRESENT_BIT] = bus_power_present;
            next_readdata[`STAT_OSC_BIT] = oscillator_enable;
            next_readdata[`STAT_PULLUP_BIT] = pullup_connect;
            next_readdata[`STAT_CHIP_RST_BIT] = chip_reset;
         end
         default: next_readdata = 32'h0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         readdata <= 32'h0;
      end else if (read & ~ack) begin
         readdata <= next_readdata;
      end
   end

   // Preserved across chip reset: only the async reset touches these
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         usb_control_reg <= `USB_CTRL_RST;
         pin_control_reg <= `PIN_CTRL_RST;
      end else if (wr_en) begin
         if (address == `OFS_USB_CTRL) begin
            usb_control_reg.connect <= writedata[`USB_CONNECT_BIT];
            usb_control_reg.bus_power_gating_enable <= writedata[`USB_GATE_BIT];
         end
         if (address == `OFS_PIN_CTRL) begin
            pin_control_reg.irq_level_mode_select <= writedata[`PIN_LEVEL_BIT];
            pin_control_reg.irq_edge_polarity_select <= writedata[`PIN_POL_BIT];
         end
      end
   end

   // Cleared by chip reset
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pin_enable <= 1'b0;
         suspend_request <= 1'b0;
      end else if (chip_reset) begin
         irq_pin_enable <= 1'b0;
         suspend_request <= 1'b0;
      end else if (wr_en) begin
         if (address == `OFS_CPU_CTRL) begin
            irq_pin_enable <= writedata[`CPU_IE_BIT];
         end
         if (address == `OFS_POWER) begin
            suspend_request <= writedata[`POWER_SUSPEND_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pullup_connect <= 1'b0;
      end else begin
         pullup_connect <= usb_control_reg.connect &
            (~usb_control_reg.bus_power_gating_enable | bus_power_present);
      end
   end

   // Event sources
   always_comb begin
      set_vec.bus_power_lost = vbus_prev & ~bus_power_present;
      set_vec.packet_received = packet_received_evt;
      set_vec.packet_sent = packet_sent_evt;
      set_vec.bus_suspend = bus_suspend_evt;
      set_vec.bus_resume = bus_resume_evt;
      set_vec.osc_ready = osc_ready_pulse;
   end
   assign clr_vec = (wr_en && address == `OFS_IRQ_FLAGS) ? writedata[`FLAGS_MSB:0] :
      `FLAGS_RST;

   // Write one to clear; a set in the same cycle wins
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= `FLAGS_RST;
         prev_flags <= `FLAGS_RST;
      end else if (chip_reset) begin
         flags <= `FLAGS_RST;
         prev_flags <= `FLAGS_RST;
      end else begin
         flags <= (flags & ~clr_vec) | set_vec;
         prev_flags <= flags;
      end
   end

   assign pending = |flags;
   assign edge_event = (|(flags & ~prev_flags)) | ((|(prev_flags & ~flags)) & pending);

   // Gap forces a fresh edge even if the pin was already active
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap_cnt <= '0;
      end else if (edge_event) begin
         gap_cnt <= `GAP_W'(GAP_CYC);
      end else if (gap_cnt != '0) begin
         gap_cnt <= gap_cnt - `GAP_W'(1);
      end
   end
   // Held off while the gap loads, else a lone request gives two edges
   assign asserted = irq_pin_enable & pending & (gap_cnt == '0) & ~edge_event;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_pin_out <= 1'b0;
         irq_pin_oe <= 1'b0;
      end else if (pin_control_reg.irq_level_mode_select) begin
         // Gap not applied: level pin tracks irq_pin_enable and pending only
         irq_pin_out <= 1'b0;
         irq_pin_oe <= irq_pin_enable & pending;
      end else begin
         irq_pin_oe <= 1'b1;
         irq_pin_out <= pin_control_reg.irq_edge_polarity_select ? asserted : ~asserted;
      end
   end

   // Oscillator control
   always_comb begin
      next_osc_state = osc_state;
      case (osc_state)
         usb_pin_ctrl_pkg::OSC_RUN:
            if (suspend_request) next_osc_state = usb_pin_ctrl_pkg::OSC_ENTERING;
         usb_pin_ctrl_pkg::OSC_ENTERING:
            if (!suspend_request) next_osc_state = usb_pin_ctrl_pkg::OSC_RUN;
            else if (osc_timer == '0) next_osc_state = usb_pin_ctrl_pkg::OSC_STOPPED;
         usb_pin_ctrl_pkg::OSC_STOPPED:
            if (!suspend_request) next_osc_state = usb_pin_ctrl_pkg::OSC_STARTING;
         usb_pin_ctrl_pkg::OSC_STARTING:
            if (suspend_request) next_osc_state = usb_pin_ctrl_pkg::OSC_ENTERING;
            else if (osc_timer == '0) next_osc_state = usb_pin_ctrl_pkg::OSC_RUN;
         default: next_osc_state = usb_pin_ctrl_pkg::OSC_RUN;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_state <= usb_pin_ctrl_pkg::OSC_RUN;
         osc_timer <= '0;
         oscillator_enable <= 1'b1;
         osc_ready_pulse <= 1'b0;
      end else if (chip_reset) begin
         osc_state <= usb_pin_ctrl_pkg::OSC_RUN;
         osc_timer <= '0;
         oscillator_enable <= 1'b1;
         osc_ready_pulse <= 1'b0;
      end else begin
         osc_state <= next_osc_state;
         oscillator_enable <= next_osc_state != usb_pin_ctrl_pkg::OSC_STOPPED;
         osc_ready_pulse <= osc_state == usb_pin_ctrl_pkg::OSC_STARTING &&
            next_osc_state == usb_pin_ctrl_pkg::OSC_RUN;
         if (next_osc_state == usb_pin_ctrl_pkg::OSC_ENTERING &&
               osc_state != usb_pin_ctrl_pkg::OSC_ENTERING) begin
            // One cycle already spent seeing the request, so stop lands on the limit
            osc_timer <= `OSC_TIMER_W'(ENTER_CYC - 2);
         end else if (next_osc_state == usb_pin_ctrl_pkg::OSC_STARTING &&
               osc_state != usb_pin_ctrl_pkg::OSC_STARTING) begin
            osc_timer <= `OSC_TIMER_W'(OSC_START_CYCLES - 1);
         end else if (osc_timer != '0) begin
            osc_timer <= osc_timer - `OSC_TIMER_W'(1);
         end
      end
   end

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   a_pullup_on: assert property (
      usb_control_reg.connect && !usb_control_reg.bus_power_gating_enable |=> pullup_connect)
      else $error("pullup not connected");

   a_pullup_gated: assert property (
      usb_control_reg.bus_power_gating_enable && !bus_power_present |=> !pullup_connect)
      else $error("pullup not gated off");

   a_vbus_loss_flag: assert property (
      $fell(bus_power_present) && !chip_reset |=> flags.bus_power_lost)
      else $error("bus power loss flag missing");

   a_chip_rst_keep: assert property (
      chip_reset && !wr_en |=> $stable(usb_control_reg) && $stable(pin_control_reg)
         && flags == `FLAGS_RST && !irq_pin_enable)
      else $error("chip reset handling wrong");

   a_irq_disabled: assert property (
      !$past(irq_pin_enable) && $stable(pin_control_reg) |->
         ($past(pin_control_reg.irq_level_mode_select) ? !irq_pin_oe :
          irq_pin_oe && irq_pin_out != $past(pin_control_reg.irq_edge_polarity_select)))
      else $error("disabled irq pin not inactive");

   a_level_drive: assert property (
      pin_control_reg.irq_level_mode_select && irq_pin_enable && pending
         |=> irq_pin_oe && !irq_pin_out)
      else $error("level irq not driven low");

   a_level_release: assert property (
      pin_control_reg.irq_level_mode_select && !pending |=> !irq_pin_oe)
      else $error("level irq held without request");

   a_edge_push: assert property (
      !pin_control_reg.irq_level_mode_select |=> irq_pin_oe)
      else $error("edge mode pin not driven");

   a_edge_gap: assert property (
      !pin_control_reg.irq_level_mode_select && edge_event && !wr_en ##1 !wr_en
         |=> irq_pin_out != pin_control_reg.irq_edge_polarity_select)
      else $error("edge event produced no inactive gap");

   a_edge_fresh: assert property (
      !pin_control_reg.irq_level_mode_select && edge_event && !wr_en
         |=> irq_pin_out != pin_control_reg.irq_edge_polarity_select)
      else $error("edge event did not start inactive");

   a_edge_active: assert property (
      !pin_control_reg.irq_level_mode_select && irq_pin_enable && pending && gap_cnt == '0
         && !edge_event && !wr_en |=> irq_pin_out == pin_control_reg.irq_edge_polarity_select)
      else $error("edge irq wrong active level");

   a_event_flag: assert property (
      (packet_received_evt || packet_sent_evt) && !chip_reset
         |=> (flags.packet_received || !$past(packet_received_evt))
         && (flags.packet_sent || !$past(packet_sent_evt)))
      else $error("packet event flag lost");

   a_bus_event_flag: assert property (
      (bus_suspend_evt || bus_resume_evt) && !chip_reset
         |=> (flags.bus_suspend || !$past(bus_suspend_evt))
         && (flags.bus_resume || !$past(bus_resume_evt)))
      else $error("bus activity event flag lost");

   a_suspend_stop: assert property (
      osc_state == usb_pin_ctrl_pkg::OSC_ENTERING |-> osc_timer < `OSC_TIMER_W'(ENTER_CYC))
      else $error("suspend entry too slow");

   a_suspend_off: assert property (
      osc_state == usb_pin_ctrl_pkg::OSC_ENTERING && osc_timer == '0 && suspend_request
         && !chip_reset |=> !oscillator_enable)
      else $error("oscillator not stopped");

   a_osc_ready: assert property (
      osc_state == usb_pin_ctrl_pkg::OSC_STARTING && osc_timer == '0 && !suspend_request
         && !chip_reset |=> ##1 flags.osc_ready)
      else $error("oscillator ready flag missing");

   c_level_irq: cover property (pin_control_reg.irq_level_mode_select && irq_pin_oe);
   c_edge_retrigger: cover property (!pin_control_reg.irq_level_mode_select && edge_event
      && |prev_flags && pending);
   c_osc_restart: cover property (osc_ready_pulse);
   c_osc_stopped: cover property (osc_state == usb_pin_ctrl_pkg::OSC_STOPPED);
   c_vbus_loss: cover property ($fell(bus_power_present) && usb_control_reg.connect);

endmodule

/* File: bench/irq_host_model.sv */
`timescale 1ns/10ps
module irq_host_model #(
   parameter int unsigned RESET_LOW_CYCLES = 20
) (
   input wire logic ref_clk,
   input wire logic irq_pin_out,
   input wire logic irq_pin_oe,
   input wire logic reset_go,
   output logic irq_wire,
   output logic chip_reset_pin_n,
   output logic reset_busy
);
   int unsigned low_cnt;
   // Board pull-up: an undriven line reads high, never a stale value
   assign irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;
   initial begin
      chip_reset_pin_n = 1'b1;
      reset_busy = 1'b0;
      low_cnt = 0;
   end
   // Whole clocks only, so the low pulse never falls short of 200 ns
   always @(posedge ref_clk) begin
      if (reset_go && !reset_busy) begin
         chip_reset_pin_n <= 1'b0;
         reset_busy <= 1'b1;
         low_cnt <= RESET_LOW_CYCLES;
      end else if (reset_busy) begin
         if (low_cnt > 1) begin
            low_cnt <= low_cnt - 1;
         end else begin
            chip_reset_pin_n <= 1'b1;
            reset_busy <= 1'b0;
         end
      end
   end
endmodule

/* File: bench/tb.sv */
`timescale 1ns/10ps
`include "usb_pin_ctrl_defs.svh"
module tb;
   localparam int unsigned OSC_CYC = 50;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [4:0] address = 5'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic bus_power_sense_input = 1'b1;
   logic [3:0] evt = 4'h0;
   logic pullup_connect, irq_pin_out, irq_pin_oe, oscillator_enable;
   logic irq_wire, chip_reset_pin_n, reset_busy;
   logic reset_go = 1'b0;
   logic [31:0] rd;
   int err_total = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #5 ref_clk = ~ref_clk;

   usb_pin_ctrl #(.OSC_START_CYCLES(OSC_CYC)) u_dut (
      .ref_clk(ref_clk), .arst_n(arst_n), .chip_reset_pin_n(chip_reset_pin_n),
      .address(address), .read(read), .write(write), .byteenable(byteenable),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .bus_power_sense_input(bus_power_sense_input), .packet_received_evt(evt[0]),
      .packet_sent_evt(evt[1]), .bus_suspend_evt(evt[2]), .bus_resume_evt(evt[3]),
      .pullup_connect(pullup_connect), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
      .oscillator_enable(oscillator_enable)
   );

   irq_host_model u_host (
      .ref_clk(ref_clk), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
      .reset_go(reset_go), .irq_wire(irq_wire), .chip_reset_pin_n(chip_reset_pin_n),
      .reset_busy(reset_busy)
   );

   task give_verdict;
      $display("mismatches %0d of %0d compares", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Request held until waitrequest is seen low at a rising edge
   task bus(input logic wr_n_rd, input logic [4:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      byteenable <= 4'hf;
      write <= wr_n_rd;
      read <= ~wr_n_rd;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge ref_clk);
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(rd, exp, what);
   endtask

   task pulse(input int i);
      evt[i] <= 1'b1;
      @(posedge ref_clk);
      evt[i] <= 1'b0;
      @(posedge ref_clk);
   endtask

   task wait_irq(input logic v, output bit ok);
      ok = 1'b0;
      for (int k = 0; k < 30 && !ok; k++) begin
         @(posedge ref_clk);
         ok = (irq_wire === v);
      end
   endtask

   task t_defaults;
      check(irq_pin_oe, 1'b0, "irq idle after reset");
      rd_chk(`OFS_PIN_CTRL, 32'h1, "pin ctrl default");
      rd_chk(`OFS_USB_CTRL, 32'h0, "usb ctrl default");
      rd_chk(`OFS_CPU_CTRL, 32'h0, "irq enable default");
      wr(5'h1c, 32'hff);
      rd_chk(5'h1c, 32'h0, "unmapped read");
   endtask

   task t_pullup;
      for (int i = 0; i < 8; i++) begin
         bus_power_sense_input <= i[2];
         wr(`OFS_USB_CTRL, {30'h0, i[1:0]});
         repeat (6) @(posedge ref_clk);
         check(pullup_connect, i[0] & (~i[1] | i[2]), "pullup gating");
      end
      rd_chk(`OFS_STATUS, 32'h7, "status bits");
   endtask

   task t_power_loss;
      wr(`OFS_IRQ_FLAGS, 32'h3f);
      rd_chk(`OFS_IRQ_FLAGS, 32'h0, "flags cleared");
      bus_power_sense_input <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd_chk(`OFS_IRQ_FLAGS, 32'h1, "bus power lost flag");
      wr(`OFS_IRQ_FLAGS, 32'h1);
      bus_power_sense_input <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd_chk(`OFS_IRQ_FLAGS, 32'h0, "no flag on return");
   endtask

   task t_level;
      wr(`OFS_PIN_CTRL, 32'h3);
      wr(`OFS_CPU_CTRL, 32'h0);
      pulse(0);
      repeat (4) @(posedge ref_clk);
      check(irq_wire, 1'b1, "level disabled floats");
      wr(`OFS_CPU_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk);
      check(irq_wire, 1'b0, "level pulled low");
      for (int i = 1; i < 4; i++) pulse(i);
      rd_chk(`OFS_IRQ_FLAGS, 32'h1e, "event flags");
      for (int i = 1; i < 5; i++) begin
         wr(`OFS_IRQ_FLAGS, 32'h1 << i);
         repeat (3) @(posedge ref_clk);
         check(irq_wire, (i == 4), "level held to last clear");
      end
   endtask

   task t_edge;
      bit ok;
      for (int p = 0; p < 2; p++) begin
         wr(`OFS_CPU_CTRL, 32'h0);
         wr(`OFS_PIN_CTRL, {30'h0, p[0], 1'b0});
         repeat (3) @(posedge ref_clk);
         check(irq_pin_oe, 1'b1, "edge push-pull");
         check(irq_pin_out, !p[0], "edge idle level");
         wr(`OFS_CPU_CTRL, 32'h1);
         pulse(0);
         wait_irq(p[0], ok);
         check(ok, 1'b1, "active on request");
         pulse(1);
         wait_irq(~p[0], ok);
         check(ok, 1'b1, "gap on second request");
         wait_irq(p[0], ok);
         check(ok, 1'b1, "edge on second request");
         wr(`OFS_IRQ_FLAGS, 32'h2);
         wait_irq(~p[0], ok);
         check(ok, 1'b1, "gap on clear with pending");
         wait_irq(p[0], ok);
         check(ok, 1'b1, "edge on clear with pending");
         wr(`OFS_IRQ_FLAGS, 32'h3f);
         repeat (20) @(posedge ref_clk);
         check(irq_wire, !p[0], "inactive when idle");
      end
   endtask

   task t_chip_reset;
      wr(`OFS_USB_CTRL, 32'h1);
      wr(`OFS_PIN_CTRL, 32'h0);
      wr(`OFS_CPU_CTRL, 32'h1);
      pulse(0);
      reset_go <= 1'b1;
      @(posedge ref_clk);
      reset_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
      while (reset_busy !== 1'b0) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      check(irq_pin_out, 1'b1, "irq inactive after reset");
      rd_chk(`OFS_USB_CTRL, 32'h1, "usb ctrl kept");
      rd_chk(`OFS_PIN_CTRL, 32'h0, "pin ctrl kept");
      rd_chk(`OFS_CPU_CTRL, 32'h0, "enable cleared");
      rd_chk(`OFS_IRQ_FLAGS, 32'h0, "flags cleared");
      wr(`OFS_PIN_CTRL, 32'h1);
   endtask

   task t_suspend;
      int n;
      n = 0;
      wr(`OFS_POWER, 32'h1);
      while (oscillator_enable !== 1'b0 && n < 600) begin
         @(posedge ref_clk);
         n++;
      end
      check(n <= 500, 1'b1, "oscillator stop time");
      wr(`OFS_POWER, 32'h0);
      @(posedge ref_clk);
      check(oscillator_enable, 1'b1, "oscillator restart");
      repeat (OSC_CYC / 2) @(posedge ref_clk);
      rd_chk(`OFS_IRQ_FLAGS, 32'h0, "ready flag too early");
      repeat (OSC_CYC) @(posedge ref_clk);
      rd_chk(`OFS_IRQ_FLAGS, 32'h20, "oscillator ready flag");
   endtask

   // Whole run needs about a thousand clocks; this only cuts a hang short
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         $display("unexpected at %0t: run timed out", $time);
         give_verdict;
      end
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      t_defaults;
      t_pullup;
      t_power_loss;
      t_level;
      t_edge;
      t_chip_reset;
      t_suspend;
      give_verdict;
   end
endmodule
